/* File: common/fsp_pkg.sv */
// constants, types and register map of the flash section protection block
package fsp_pkg;

    // ----------------------------------------------------------------
    // memory geometry
    // ----------------------------------------------------------------
    localparam int unsigned FLASH_AW    = 15;
    localparam int unsigned PAGE_SHIFT  = 9;
    localparam logic [16:0] FLASH_BYTES = 17'h0_8000;
    localparam int unsigned EE_AW       = 8;
    localparam logic [2:0]  SPAN_MAX    = 3'h5;
    localparam logic [2:0]  SPAN_ONE    = 3'h0;
    localparam logic [2:0]  SPAN_TWO    = 3'h1;
    localparam logic [7:0]  FUSE_ZERO   = 8'h00;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0]  REG_CTRL      = 8'h00;
    localparam logic [7:0]  REG_STAT      = 8'h04;
    localparam logic [7:0]  REG_BOUND     = 8'h08;
    localparam logic [7:0]  REG_FUSE      = 8'h0C;
    localparam int unsigned CTRL_RLOCK    = 0;
    localparam int unsigned CTRL_CLOCK    = 1;
    localparam int unsigned CTRL_DLOCK    = 2;
    localparam int unsigned CTRL_VSEL     = 3;
    localparam int unsigned CTRL_CMD_LSB  = 4;
    localparam int unsigned CTRL_SPAN_LSB = 8;
    localparam int unsigned STAT_DENIED   = 2;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    localparam logic [31:0] DATA_ZERO     = 32'h0000_0000;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {SEC_LOADER, SEC_CODE, SEC_DATA} fsp_sec_t;

    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_FL_WRITE,
        CMD_FL_PAGE_ERASE,
        CMD_FL_MULTI_ERASE,
        CMD_EE_WRITE,
        CMD_EE_ERASE,
        CMD_EE_ERASE_WRITE
    } fsp_cmd_t;

    typedef enum logic [1:0] {ST_IDLE, ST_FLASH, ST_EEPROM} fsp_state_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        eeprom;
        logic        word;
        logic [15:0] addr;
        logic [15:0] data;
    } fsp_req_t;

    typedef struct packed {
        fsp_cmd_t    kind;
        logic [15:0] addr;
        logic [2:0]  span_log;
        logic [15:0] data;
    } fsp_op_t;

endpackage

/* File: rtl/fsp_flash_section_protection.sv */
// flash section partitioning, self-programming protection and lock bits
// ----------------------------------------------------------------
// What this block does
// - flash pages are 512 bytes; erase by whole pages, write by byte or word
// - both size fuses count 512-byte blocks for the section boundaries
// - loader section runs from flash address zero to the loader end boundary
// - loader size fuse zero makes the whole flash the loader section
// - code fuse zero, loader nonzero: code section to flash end, no data section
// - code fuse not above loader fuse: no code section, data section to flash end
// - code fuse above loader fuse: code to code end, data section above it
// - a boundary above the flash size (FLASH_BYTES) replaces that fuse by its default
// - never write the section the issuing code is executing from
// - the loader section is never writable by the CPU
// - code section writable only while executing from the loader
// - data section writable only while executing from loader or code section
// - flash programming halts the CPU, EEPROM does not; data-section code denied
// - read lock blocks reads and fetches of the loader by outside code
// - read lock settable only from loader code, effective once execution leaves
// - code and data write locks, once set, block further programming
// - vectors at code section start after reset, select bit moves them to loader
// - EEPROM of 256 bytes, byte writes, erase blocks of 1 to 32 bytes
// - EEPROM erase-then-write of one byte in a single command
// - reads during a write or erase wait until it completes
//
// Our own choices: register access over AXI4-Lite and the register offsets.
module fsp_flash_section_protection
    import fsp_pkg::*;
#(
    parameter logic [7:0] DEFAULT_LOADER_SIZE = 8'h00,
    parameter logic [7:0] DEFAULT_CODE_SIZE   = 8'h00
)
(
    // clock and reset
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic                aclken,
    // fuse loader
    input  wire logic [7:0]          loader_size_fuse,
    input  wire logic [7:0]          code_size_fuse,
    input  wire logic                startup_done,
    // cpu side
    input  wire logic [FLASH_AW-1:0] fetch_addr,
    input  wire fsp_req_t            cpu_req,
    output logic                     cpu_ack,
    output logic                     cpu_wait,
    output logic                     cpu_halt,
    output logic                     req_denied,
    output logic                     read_blocked,
    output logic                     fetch_blocked,
    output logic [FLASH_AW-1:0]      vector_base,
    // memory array side
    output fsp_op_t                  nvm_op,
    output logic                     op_start,
    input  wire logic                op_done,
    // axi4-lite slave
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready
);

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    function automatic logic [16:0] block_end(input logic [7:0] blocks);
        block_end = {blocks, {PAGE_SHIFT{1'b0}}};
    endfunction

    function automatic fsp_sec_t section_of(input logic [FLASH_AW-1:0] a,
                                            input logic [7:0] bsz,
                                            input logic [7:0] csz);
        if (bsz == FUSE_ZERO)
            section_of = SEC_LOADER;
        else if ({2'b00, a} < block_end(bsz))
            section_of = SEC_LOADER;
        else if (csz == FUSE_ZERO)
            section_of = SEC_CODE;
        else if (csz <= bsz)
            section_of = SEC_DATA;
        else if ({2'b00, a} < block_end(csz))
            section_of = SEC_CODE;
        else
            section_of = SEC_DATA;
    endfunction

    function automatic logic [15:0] align(input logic [15:0] a, input logic [3:0] sh);
        align = a & ~((16'h0001 << sh) - 16'h0001);
    endfunction

    function automatic logic [7:0] fuse_check(input logic [7:0] f, input logic [7:0] dflt);
        fuse_check = (block_end(f) > FLASH_BYTES) ? dflt : f;
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    fsp_state_t     state;
    logic           fuse_valid;
    logic [7:0]     boot_sz;
    logic [7:0]     code_sz;
    logic           rlock;
    logic           clock_bit;
    logic           dlock;
    logic           vsel;
    fsp_cmd_t       cmd;
    logic [2:0]     span_req;
    logic           lock_active;
    logic           denied_flag;

    // ----------------------------------------------------------------
    // section decode and permission
    // ----------------------------------------------------------------
    wire fsp_sec_t  exec_sec = section_of(fetch_addr, boot_sz, code_sz);
    wire fsp_sec_t  tgt_sec  = section_of(cpu_req.addr[FLASH_AW-1:0], boot_sz, code_sz);

    wire logic      fl_cmd   = (cmd == CMD_FL_WRITE) || (cmd == CMD_FL_PAGE_ERASE)
                               || (cmd == CMD_FL_MULTI_ERASE);
    wire logic      ee_cmd   = (cmd == CMD_EE_WRITE) || (cmd == CMD_EE_ERASE)
                               || (cmd == CMD_EE_ERASE_WRITE);

    // same-section writes fall out: loader never, code only from loader
    wire logic      code_ok  = (exec_sec == SEC_LOADER) && !clock_bit;
    wire logic      data_ok  = (exec_sec != SEC_DATA) && !dlock;
    wire logic      fl_ok    = (tgt_sec == SEC_CODE) ? code_ok
                             : (tgt_sec == SEC_DATA) ? data_ok
                             : 1'b0;
    wire logic      ee_ok    = exec_sec != SEC_DATA;
    wire logic      write_ok = cpu_req.eeprom ? (ee_ok && ee_cmd) : (fl_ok && fl_cmd);

    wire logic      rd_block = !cpu_req.eeprom && (lock_active || rlock)
                               && (tgt_sec == SEC_LOADER) && (exec_sec != SEC_LOADER);
    wire logic      take     = cpu_req.valid && (state == ST_IDLE) && !cpu_ack;
    wire logic      start_op = take && cpu_req.write && write_ok;

    // ----------------------------------------------------------------
    // operation shaping
    // ----------------------------------------------------------------
    wire logic [2:0] span_fl = (span_req > SPAN_MAX) ? SPAN_MAX
                             : (span_req < SPAN_TWO) ? SPAN_TWO : span_req;
    wire logic [2:0] span_ee = (span_req > SPAN_MAX) ? SPAN_MAX : span_req;
    wire logic [15:0] ee_addr = {{(16-EE_AW){1'b0}}, cpu_req.addr[EE_AW-1:0]};

    fsp_op_t next_op;
    always_comb
    begin
        next_op.kind     = cmd;
        next_op.data     = cpu_req.data;
        next_op.span_log = SPAN_ONE;
        next_op.addr     = cpu_req.addr;
        case (cmd)
            CMD_FL_WRITE:
                next_op.addr = cpu_req.word ? align(cpu_req.addr, 4'h1) : cpu_req.addr;
            CMD_FL_PAGE_ERASE:
                next_op.addr = align(cpu_req.addr, 4'(PAGE_SHIFT));
            CMD_FL_MULTI_ERASE:
            begin
                next_op.span_log = span_fl;
                next_op.addr     = align(cpu_req.addr, 4'(PAGE_SHIFT) + {1'b0, span_fl});
            end
            CMD_EE_ERASE:
            begin
                next_op.span_log = span_ee;
                next_op.addr     = align(ee_addr, {1'b0, span_ee});
            end
            CMD_EE_WRITE, CMD_EE_ERASE_WRITE:
                next_op.addr = ee_addr;
            default:
                next_op.addr = cpu_req.addr;
        endcase
    end

    // ----------------------------------------------------------------
    // fuse sampling
    // ----------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            fuse_valid <= 1'b0;
            boot_sz    <= FUSE_ZERO;
            code_sz    <= FUSE_ZERO;
        end
        else if (aclken && startup_done && !fuse_valid)
        begin
            // taken once only; later fuse changes are ignored until reset
            fuse_valid <= 1'b1;
            boot_sz    <= fuse_check(loader_size_fuse, DEFAULT_LOADER_SIZE);
            code_sz    <= fuse_check(code_size_fuse, DEFAULT_CODE_SIZE);
        end
    end

    // ----------------------------------------------------------------
    // request handling
    // ----------------------------------------------------------------
    wire fsp_state_t op_state = cpu_req.eeprom ? ST_EEPROM : ST_FLASH;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state        <= ST_IDLE;
            cpu_ack      <= 1'b0;
            cpu_wait     <= 1'b0;
            cpu_halt     <= 1'b0;
            req_denied   <= 1'b0;
            read_blocked <= 1'b0;
            op_start     <= 1'b0;
            nvm_op       <= '0;
        end
        else if (aclken)
        begin
            cpu_ack      <= take;
            req_denied   <= take && cpu_req.write && !write_ok;
            read_blocked <= take && !cpu_req.write && rd_block;
            op_start     <= start_op;
            cpu_wait     <= cpu_req.valid && (state != ST_IDLE) && !op_done;
            if (start_op)
            begin
                nvm_op   <= next_op;
                state    <= op_state;
                cpu_halt <= !cpu_req.eeprom;
            end
            else if ((state != ST_IDLE) && op_done)
            begin
                state    <= ST_IDLE;
                cpu_halt <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // read lock and vector base
    // ----------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            lock_active   <= 1'b0;
            fetch_blocked <= 1'b0;
            vector_base   <= '0;
        end
        else if (aclken)
        begin
            if (rlock && (exec_sec != SEC_LOADER))
                lock_active <= 1'b1;
            fetch_blocked <= lock_active && (exec_sec == SEC_LOADER);
            vector_base   <= vsel ? '0 : FLASH_AW'(block_end(boot_sz));
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite write channel
    // ----------------------------------------------------------------
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    wire  logic  do_write  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    wire  logic  wr_ctrl   = do_write && (aw_addr == REG_CTRL);
    wire  logic  wr_stat   = do_write && (aw_addr == REG_STAT);
    wire  logic  wr_known  = wr_ctrl || wr_stat || (aw_addr == REG_BOUND)
                             || (aw_addr == REG_FUSE);
    wire  logic  loader_wr = exec_sec == SEC_LOADER;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            aw_addr       <= '0;
            w_data        <= DATA_ZERO;
            w_strb        <= '0;
        end
        else if (aclken)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rlock       <= 1'b0;
            clock_bit   <= 1'b0;
            dlock       <= 1'b0;
            vsel        <= 1'b0;
            cmd         <= CMD_NONE;
            span_req    <= SPAN_ONE;
            denied_flag <= 1'b0;
        end
        else if (aclken)
        begin
            if (wr_ctrl && w_strb[0])
            begin
                // locks only ever set; clearing needs a reset
                if (w_data[CTRL_RLOCK] && loader_wr)
                    rlock <= 1'b1;
                if (w_data[CTRL_CLOCK])
                    clock_bit <= 1'b1;
                if (w_data[CTRL_DLOCK])
                    dlock <= 1'b1;
                vsel <= w_data[CTRL_VSEL];
                cmd  <= fsp_cmd_t'(w_data[CTRL_CMD_LSB +: 3]);
            end
            if (wr_ctrl && w_strb[1])
                span_req <= w_data[CTRL_SPAN_LSB +: 3];
            // a new denial wins over a clear in the same cycle
            if (take && cpu_req.write && !write_ok)
                denied_flag <= 1'b1;
            else if (wr_stat && w_strb[0] && w_data[STAT_DENIED])
                denied_flag <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite read channel
    // ----------------------------------------------------------------
    wire logic [31:0] ctrl_view = {21'h0, span_req, 1'b0, cmd, vsel, dlock, clock_bit, rlock};
    wire logic [31:0] stat_view = {27'h0, fuse_valid, lock_active, denied_flag,
                                   state == ST_EEPROM, state == ST_FLASH};
    wire logic [31:0] bound_view = {16'(block_end(code_sz)), 16'(block_end(boot_sz))};
    wire logic [31:0] fuse_view = {16'h0, code_sz, boot_sz};
    wire logic        rd_known  = (s_axi_araddr == REG_CTRL) || (s_axi_araddr == REG_STAT)
                                  || (s_axi_araddr == REG_BOUND)
                                  || (s_axi_araddr == REG_FUSE);
    wire logic [31:0] rd_mux    = (s_axi_araddr == REG_CTRL)  ? ctrl_view
                                : (s_axi_araddr == REG_STAT)  ? stat_view
                                : (s_axi_araddr == REG_BOUND) ? bound_view
                                : (s_axi_araddr == REG_FUSE)  ? fuse_view
                                : DATA_ZERO;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= DATA_ZERO;
            s_axi_rresp   <= RESP_OKAY;
        end
        else if (aclken)
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_mux;
                s_axi_rresp   <= rd_known ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule

/* File: verif/fsp_flash_section_protection_tb_top.sv */
// self-checking testbench of the flash section protection block
module fsp_flash_section_protection_tb_top
    import fsp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        aclk, aresetn, aclken, startup_done, cpu_ack, cpu_halt, req_denied;
    logic        read_blocked, op_start, op_done, s_axi_awvalid, s_axi_awready, fetch_blocked;
    logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]  loader_size_fuse, code_size_fuse, s_axi_awaddr, s_axi_araddr;
    logic [14:0] fetch_addr, vector_base;
    logic [3:0]  lat, s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed;
    fsp_req_t    cpu_req;
    logic [2:0]  cpu_q[$];
    logic [33:0] ax_q[$];
    logic [34:0] tbl[0:10];
    int          error_cnt, tests_run;

    fsp_flash_section_protection fsp_flash_section_protection_i (
        .aclk, .aresetn, .aclken, .loader_size_fuse, .code_size_fuse, .startup_done,
        .fetch_addr, .cpu_req, .cpu_ack, .cpu_wait(), .cpu_halt, .req_denied,
        .read_blocked, .fetch_blocked, .vector_base, .nvm_op(), .op_start, .op_done,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready
    );
    fsp_nvm_model fsp_nvm_model_i (.aclk, .aresetn, .op_start, .lat, .op_done);

    always #2.5 aclk = ~aclk;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [31:0] ctrl(input logic [2:0] cmd, input logic [3:0] bits);
        return (32'(cmd) << CTRL_CMD_LSB) | 32'(bits);
    endfunction

    task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wrap_up();
        if (error_cnt == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // bus and cpu drivers
    // ----------------------------------------------------------------
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        ax_q.push_back({r, DATA_ZERO});
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid || s_axi_wvalid);
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
        ax_q.push_back(e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask

    task automatic cpu_op(input logic [14:0] f, input logic [15:0] a, input logic ee,
                          input logic wr, input logic [2:0] e);
        logic [31:0] r;
        r = xs();
        cpu_q.push_back(e);
        @(posedge aclk);
        fetch_addr <= f;
        lat <= r[19:16];
        cpu_req <= '{1'b1, wr, ee, 1'b0, a, r[15:0]};
        do @(posedge aclk); while (cpu_ack !== 1'b1);
        cpu_req.valid <= 1'b0;
    endtask

    always @(posedge aclk)
    begin
        if (cpu_ack === 1'b1 && cpu_q.size() > 0)
            chk("cpu result", 34'({req_denied, read_blocked, op_start}),
                34'(cpu_q.pop_front()));
        if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
            chk("write response", {s_axi_bresp, DATA_ZERO}, ax_q.pop_front());
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
            chk("read data", {s_axi_rresp, s_axi_rdata}, ax_q.pop_front());
    end

    initial
    begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        wrap_up();
    end

    initial
    begin
        {aclk, aresetn, startup_done, lat, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {fetch_addr, cpu_req, error_cnt, tests_run} = '0;
        aclken = 1'b1;
        s_axi_wstrb = 4'hf;
        seed = 32'h0001_3FB5;
        loader_size_fuse = 8'h04;
        code_size_fuse = 8'h08;
        // fetch section, target, eeprom, expected {denied, blocked, start}
        tbl = '{{15'h0100, 16'h0200, 1'b0, 3'b100}, {15'h0100, 16'h0A00, 1'b0, 3'b001},
                {15'h0100, 16'h2000, 1'b0, 3'b001}, {15'h0100, 16'h0010, 1'b1, 3'b001},
                {15'h0900, 16'h0300, 1'b0, 3'b100}, {15'h0900, 16'h0C00, 1'b0, 3'b100},
                {15'h0900, 16'h4000, 1'b0, 3'b001}, {15'h0900, 16'h0020, 1'b1, 3'b001},
                {15'h2000, 16'h4000, 1'b0, 3'b100}, {15'h2000, 16'h0030, 1'b1, 3'b100},
                {15'h2000, 16'h0A00, 1'b0, 3'b100}};
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        startup_done <= 1'b1;
        repeat (3) @(posedge aclk);
        // later fuse changes must not move the boundaries
        loader_size_fuse <= 8'h00;
        code_size_fuse <= 8'h03;
        chk("vector base", 34'(vector_base), 34'h0800);
        for (int i = 0; i < 11; i++)
        begin
            axi_wr(REG_CTRL, ctrl(tbl[i][3] ? 3'h4 : 3'h1, 4'h0), RESP_OKAY);
            cpu_op(tbl[i][34:20], tbl[i][19:4], tbl[i][3], 1'b1, tbl[i][2:0]);
        end
        axi_rd(REG_BOUND, {RESP_OKAY, 32'h1000_0800});
        axi_wr(REG_CTRL, ctrl(3'h1, 4'h2), RESP_OKAY);
        cpu_op(15'h0100, 16'h0A00, 1'b0, 1'b1, 3'b100);
        axi_wr(REG_CTRL, ctrl(3'h1, 4'h8), RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk("vector base", 34'(vector_base), 34'h0000);
        axi_wr(8'h40, 32'h0000_0001, RESP_SLVERR);
        axi_wr(REG_CTRL, ctrl(3'h0, 4'h1), RESP_OKAY);
        cpu_op(15'h0900, 16'h0010, 1'b0, 1'b0, 3'b010);
        cpu_op(15'h0900, 16'h0010, 1'b1, 1'b0, 3'b000);
        fetch_addr <= 15'h0100;
        repeat (2) @(posedge aclk);
        chk("fetch block", 34'(fetch_blocked), 34'h0001);
        wrap_up();
    end
endmodule

/* File: verif/fsp_nvm_model.sv */
// memory array model answering each started operation after a set latency
module fsp_nvm_model
(
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // operation handshake
    input  wire logic       op_start,
    input  wire logic [3:0] lat,
    output logic            op_done
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [4:0] cnt;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt     <= 5'h00;
            op_done <= 1'b0;
        end
        else
        begin
            op_done <= (cnt == 5'h01);
            if (op_start)
                cnt <= {1'b0, lat} + 5'h02;
            else if (cnt != 5'h00)
                cnt <= cnt - 5'h01;
        end
    end
endmodule

/* File: verif/fsp_prot_checker.sv */
// assertion checker for the flash section protection block
module fsp_prot_checker
    import fsp_pkg::*;
(
    // clock and reset
    input wire logic     aclk,
    input wire logic     aresetn,
    // cpu side
    input wire fsp_req_t cpu_req,
    input wire logic     cpu_ack,
    input wire logic     cpu_wait,
    input wire logic     cpu_halt,
    input wire logic     req_denied,
    input wire logic     read_blocked,
    // memory array side
    input wire fsp_op_t  nvm_op,
    input wire logic     op_start,
    input wire logic     op_done
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence flash_start_s;
        op_start && nvm_op.kind inside {CMD_FL_WRITE, CMD_FL_PAGE_ERASE, CMD_FL_MULTI_ERASE};
    endsequence
    sequence ee_start_s;
        op_start && nvm_op.kind inside {CMD_EE_WRITE, CMD_EE_ERASE, CMD_EE_ERASE_WRITE};
    endsequence

    flash_halts_a: assert property (flash_start_s |=> cpu_halt)
        else $error("flash op left cpu running");
    eeprom_no_halt_a: assert property (ee_start_s |=> !cpu_halt)
        else $error("eeprom op halted cpu");
    halt_holds_a: assert property (cpu_halt && !op_done |=> cpu_halt)
        else $error("halt dropped early");
    halt_release_a: assert property (cpu_halt && op_done |=> !cpu_halt)
        else $error("halt held too long");
    deny_no_op_a: assert property (req_denied |-> cpu_ack && !op_start)
        else $error("denied write started op");
    start_needs_ack_a: assert property (op_start |-> cpu_ack && !req_denied)
        else $error("op without accepted write");
    wait_no_take_a: assert property (cpu_halt && cpu_req.valid |=> !cpu_ack)
        else $error("request taken during op");
    wait_flag_a: assert property (cpu_halt && cpu_req.valid && !op_done |=> cpu_wait)
        else $error("no wait during op");
    blocked_read_a: assert property (read_blocked |-> cpu_ack && !op_start)
        else $error("blocked read started op");
    denied_write_a: assert property (req_denied |-> $past(cpu_req.write))
        else $error("denial for a read");
endmodule

bind fsp_flash_section_protection fsp_prot_checker fsp_prot_checker_i (
    .aclk, .aresetn, .cpu_req, .cpu_ack, .cpu_wait, .cpu_halt, .req_denied,
    .read_blocked, .nvm_op, .op_start, .op_done
);
